// ---- hdl/ssv_pkg.sv ----
// constants, field layouts and carrier types of the supply path supervisor
// assumes a single 200 MHz clock domain and a 32-bit APB register port
package ssv_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SW_N = 8;
   localparam int IRQ_N = 3;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_RECOV_SEL = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h10;

   // control register fields
   localparam int CTRL_SEL_A = 0;
   localparam int CTRL_FORCE = 1;
   localparam int CTRL_SEL_C = 2;
   localparam int CTRL_BUCKBOOST_EN = 3;
   localparam int CTRL_SW_LSB = 8;

   // status register fields
   localparam int STAT_CMP_EN = 0;
   localparam int STAT_BAT_SW = 1;
   localparam int STAT_BUCKBOOST_SW = 2;
   localparam int STAT_OVERTEMP = 3;
   localparam int STAT_RECOV_PEND = 4;
   localparam int STAT_DIS_LSB = 8;
   localparam int STAT_SW_LSB = 16;

   // interrupt status and mask bits
   localparam int INT_COLLAPSE = 0;
   localparam int INT_RECOVER = 1;
   localparam int INT_OVERTEMP = 2;

   // values after reset
   localparam logic [SW_N-1:0] SW_CTRL_RST = 8'h00;
   localparam logic [SW_N-1:0] RECOV_SEL_RST = 8'h00;
   localparam logic [IRQ_N-1:0] INT_MASK_RST = 3'h0;

   typedef struct packed {
      logic sel_a;
      logic max_supply_force_on;
      logic sel_c;
   } ssv_cfg_t;

   typedef struct packed {
      logic buckboost_output_rail_low;
      logic vin_fall;
      logic vin_rise;
      logic ot_buckboost;
      logic ot_central;
   } ssv_sense_t;

   typedef struct packed {
      logic cmp_en;
      logic bat_sw;
      logic buckboost_sw;
   } ssv_vmax_t;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_BAT = 3'b010,
      ST_OPEN = 3'b100
   } ssv_vmax_state_t;

endpackage : ssv_pkg

// ---- hdl/ssv_vmax_sel.sv ----
// max-supply node selector: comparator enable and the two rail switches
// assumes the comparator result is synchronous to clk_i
`timescale 1ns/1ps
module ssv_vmax_sel (
   input wire logic clk_i,
   input wire logic rst_i,
   input ssv_pkg::ssv_cfg_t cfg_i,
   input wire logic buckboost_enable_i,
   input wire logic rail_low_i,
   output ssv_pkg::ssv_vmax_t vmax_o
);

   ssv_pkg::ssv_vmax_state_t state_ff;
   ssv_pkg::ssv_vmax_state_t nxt_state;
   ssv_pkg::ssv_vmax_t vmax_ff;
   logic keep_run;

   assign keep_run = (state_ff == ssv_pkg::ST_RUN) && !rail_low_i;

   always_comb begin
      nxt_state = ssv_pkg::ST_RUN;
      if (cfg_i.max_supply_force_on || buckboost_enable_i) begin
         nxt_state = ssv_pkg::ST_RUN;
      end else begin
         case ({cfg_i.sel_a, cfg_i.sel_c})
            2'b00: nxt_state = ssv_pkg::ST_BAT;
            2'b10: nxt_state = ssv_pkg::ST_OPEN;
            2'b01: nxt_state = keep_run ? ssv_pkg::ST_RUN : ssv_pkg::ST_BAT;
            2'b11: nxt_state = keep_run ? ssv_pkg::ST_RUN : ssv_pkg::ST_OPEN;
            default: nxt_state = ssv_pkg::ST_OPEN;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= ssv_pkg::ST_BAT;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vmax_ff <= '0;
      end else begin
         vmax_ff.cmp_en <= (nxt_state == ssv_pkg::ST_RUN);
         vmax_ff.bat_sw <= (nxt_state == ssv_pkg::ST_BAT) ||
                           ((nxt_state == ssv_pkg::ST_RUN) && rail_low_i);
         vmax_ff.buckboost_sw <= (nxt_state == ssv_pkg::ST_RUN) && !rail_low_i;
      end
   end

   assign vmax_o = vmax_ff;

   AST_CMP_ON_ENABLED:
   assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_i.sel_a && !cfg_i.max_supply_force_on && cfg_i.sel_c && buckboost_enable_i
      |=> vmax_o.cmp_en)
   else $error("comparator off while converter enabled");

   AST_OPEN_ON_DROP:
   assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_i.sel_a && !cfg_i.max_supply_force_on && cfg_i.sel_c &&
      !buckboost_enable_i && rail_low_i
      |=> !vmax_o.bat_sw && !vmax_o.buckboost_sw && !vmax_o.cmp_en)
   else $error("max-supply switches not opened after drop");

   AST_FORCE_HIGHER:
   assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_i.max_supply_force_on
      |=> vmax_o.cmp_en && (vmax_o.bat_sw == $past(rail_low_i)) &&
          (vmax_o.buckboost_sw != $past(rail_low_i)))
   else $error("forced selection did not pick the higher rail");

endmodule : ssv_vmax_sel

// ---- hdl/ssv_supply_path_supervisor.sv ----
// supply path supervisor: APB registers, collapse recovery, thermal gating
// assumes sense inputs synchronous to clk_i and an APB master on clk_i
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module ssv_supply_path_supervisor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ssv_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [ssv_pkg::DATA_W-1:0] pwdata_i,
   output logic [ssv_pkg::DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input ssv_pkg::ssv_sense_t sense_i,
   output ssv_pkg::ssv_vmax_t vmax_o,
   output logic buckboost_enable_o,
   output logic [ssv_pkg::SW_N-1:0] sw_en_o,
   output logic overtemp_o,
   output logic irq_o
);

   // software-owned configuration
   ssv_pkg::ssv_cfg_t cfg_ff;
   logic buckboost_en_ff;
   logic [ssv_pkg::SW_N-1:0] sw_ctrl_ff;
   logic [ssv_pkg::SW_N-1:0] recov_sel_ff;
   logic [ssv_pkg::IRQ_N-1:0] int_mask_ff;

   // hardware-owned state
   logic [ssv_pkg::IRQ_N-1:0] int_stat_ff;
   logic [ssv_pkg::IRQ_N-1:0] nxt_int_stat;
   logic [ssv_pkg::SW_N-1:0] dis_ff;
   logic [ssv_pkg::SW_N-1:0] nxt_dis;
   logic fall_d_ff;
   logic rise_d_ff;
   logic ot_d_ff;

   // output flops
   logic [ssv_pkg::SW_N-1:0] sw_en_ff;
   logic [ssv_pkg::SW_N-1:0] sw_gate;
   logic buckboost_out_ff;
   logic overtemp_ff;
   logic irq_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [ssv_pkg::DATA_W-1:0] prdata_ff;

   // bus decode
   logic acc;
   logic setup_done;
   logic wr_en;
   logic hit;
   logic [ssv_pkg::DATA_W-1:0] rd_mux;

   // event decode
   logic fall_edge;
   logic rise_edge;
   logic ot_now;
   logic ot_rise;
   logic buckboost_eff;
   logic [ssv_pkg::IRQ_N-1:0] int_set;
   logic [ssv_pkg::IRQ_N-1:0] int_clr;

   assign acc = psel_i && penable_i;
   assign setup_done = acc && !pready_ff;
   assign wr_en = acc && pready_ff && pwrite_i;

   assign fall_edge = sense_i.vin_fall && !fall_d_ff;
   assign rise_edge = sense_i.vin_rise && !rise_d_ff;
   assign ot_now = sense_i.ot_buckboost || sense_i.ot_central;
   assign ot_rise = ot_now && !ot_d_ff;
   assign buckboost_eff = buckboost_en_ff && !ot_now;

   always_comb begin
      hit = 1'b1;
      rd_mux = '0;
      case (paddr_i)
         ssv_pkg::OFF_CTRL: begin
            rd_mux[ssv_pkg::CTRL_SEL_A] = cfg_ff.sel_a;
            rd_mux[ssv_pkg::CTRL_FORCE] = cfg_ff.max_supply_force_on;
            rd_mux[ssv_pkg::CTRL_SEL_C] = cfg_ff.sel_c;
            rd_mux[ssv_pkg::CTRL_BUCKBOOST_EN] = buckboost_en_ff;
            rd_mux[ssv_pkg::CTRL_SW_LSB +: ssv_pkg::SW_N] = sw_ctrl_ff;
         end
         ssv_pkg::OFF_RECOV_SEL: begin
            rd_mux[ssv_pkg::SW_N-1:0] = recov_sel_ff;
         end
         ssv_pkg::OFF_STATUS: begin
            rd_mux[ssv_pkg::STAT_CMP_EN] = vmax_o.cmp_en;
            rd_mux[ssv_pkg::STAT_BAT_SW] = vmax_o.bat_sw;
            rd_mux[ssv_pkg::STAT_BUCKBOOST_SW] = vmax_o.buckboost_sw;
            rd_mux[ssv_pkg::STAT_OVERTEMP] = overtemp_ff;
            rd_mux[ssv_pkg::STAT_RECOV_PEND] = |dis_ff;
            rd_mux[ssv_pkg::STAT_DIS_LSB +: ssv_pkg::SW_N] = dis_ff;
            rd_mux[ssv_pkg::STAT_SW_LSB +: ssv_pkg::SW_N] = sw_en_ff;
         end
         ssv_pkg::OFF_INT_STAT: begin
            rd_mux[ssv_pkg::IRQ_N-1:0] = int_stat_ff;
         end
         ssv_pkg::OFF_INT_MASK: begin
            rd_mux[ssv_pkg::IRQ_N-1:0] = int_mask_ff;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // one wait state keeps every bus output a plain flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= setup_done;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= setup_done && !hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prdata_ff <= '0;
      end else if (setup_done && !pwrite_i) begin
         prdata_ff <= rd_mux;
      end else if (!acc) begin
         prdata_ff <= '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_ff <= '0;
         buckboost_en_ff <= 1'b0;
         sw_ctrl_ff <= ssv_pkg::SW_CTRL_RST;
      end else if (wr_en && (paddr_i == ssv_pkg::OFF_CTRL)) begin
         cfg_ff.sel_a <= pwdata_i[ssv_pkg::CTRL_SEL_A];
         cfg_ff.max_supply_force_on <= pwdata_i[ssv_pkg::CTRL_FORCE];
         cfg_ff.sel_c <= pwdata_i[ssv_pkg::CTRL_SEL_C];
         buckboost_en_ff <= pwdata_i[ssv_pkg::CTRL_BUCKBOOST_EN];
         sw_ctrl_ff <= pwdata_i[ssv_pkg::CTRL_SW_LSB +: ssv_pkg::SW_N];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         recov_sel_ff <= ssv_pkg::RECOV_SEL_RST;
      end else if (wr_en && (paddr_i == ssv_pkg::OFF_RECOV_SEL)) begin
         recov_sel_ff <= pwdata_i[ssv_pkg::SW_N-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_mask_ff <= ssv_pkg::INT_MASK_RST;
      end else if (wr_en && (paddr_i == ssv_pkg::OFF_INT_MASK)) begin
         int_mask_ff <= pwdata_i[ssv_pkg::IRQ_N-1:0];
      end
   end

   // edge detectors on the monitor levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fall_d_ff <= 1'b0;
         rise_d_ff <= 1'b0;
         ot_d_ff <= 1'b0;
      end else begin
         fall_d_ff <= sense_i.vin_fall;
         rise_d_ff <= sense_i.vin_rise;
         ot_d_ff <= ot_now;
      end
   end

   always_comb begin
      nxt_dis = dis_ff;
      if (fall_edge) begin
         nxt_dis = dis_ff | (sw_ctrl_ff & recov_sel_ff);
      end else if (rise_edge) begin
         nxt_dis = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dis_ff <= '0;
      end else begin
         dis_ff <= nxt_dis;
      end
   end

   // per-switch gating: software enable, collapse shedding, thermal
   genvar g;
   generate
      for (g = 0; g < ssv_pkg::SW_N; g++) begin : g_sw
         assign sw_gate[g] = sw_ctrl_ff[g] && !nxt_dis[g] && !ot_now;
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sw_en_ff <= '0;
      end else begin
         sw_en_ff <= sw_gate;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buckboost_out_ff <= 1'b0;
         overtemp_ff <= 1'b0;
      end else begin
         buckboost_out_ff <= buckboost_eff;
         overtemp_ff <= ot_now;
      end
   end

   // sticky interrupt status; a new event wins over a write-one clear
   assign int_set = {ot_rise, rise_edge, fall_edge};
   assign int_clr = (wr_en && (paddr_i == ssv_pkg::OFF_INT_STAT)) ?
                    pwdata_i[ssv_pkg::IRQ_N-1:0] : '0;

   always_comb begin
      nxt_int_stat = (int_stat_ff & ~int_clr) | int_set;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_stat_ff <= '0;
      end else begin
         int_stat_ff <= nxt_int_stat;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(int_stat_ff & int_mask_ff);
      end
   end

   // the converter enable seen by the selector already carries thermal gating
   ssv_vmax_sel u_vmax_sel (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg_i(cfg_ff),
      .buckboost_enable_i(buckboost_eff),
      .rail_low_i(sense_i.buckboost_output_rail_low),
      .vmax_o(vmax_o)
   );

   assign prdata_o = prdata_ff;
   assign pready_o = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign buckboost_enable_o = buckboost_out_ff;
   assign sw_en_o = sw_en_ff;
   assign overtemp_o = overtemp_ff;
   assign irq_o = irq_ff;

   AST_COLLAPSE_IRQ:
   assert property (@(posedge clk_i) disable iff (rst_i)
      fall_edge && int_mask_ff[ssv_pkg::INT_COLLAPSE] && !wr_en
      |-> ##2 irq_o)
   else $error("collapse did not raise the interrupt");

   AST_COLLAPSE_SHED:
   assert property (@(posedge clk_i) disable iff (rst_i)
      fall_edge
      |=> ((sw_en_o & $past(recov_sel_ff)) == '0) &&
          ((dis_ff & $past(sw_ctrl_ff & recov_sel_ff)) == $past(sw_ctrl_ff & recov_sel_ff)))
   else $error("selected switches still on after collapse");

   AST_RECOVER_RESTORE:
   assert property (@(posedge clk_i) disable iff (rst_i)
      rise_edge && !fall_edge && !ot_now && !wr_en
      |=> (dis_ff == '0) && (sw_en_o == $past(sw_ctrl_ff)))
   else $error("shed switches not restored on recovery");

   AST_OT_COMBINE:
   assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 1'b1 |-> overtemp_o == $past(sense_i.ot_buckboost || sense_i.ot_central))
   else $error("over-temperature is not the OR of both sensors");

   AST_OT_FORCE_OFF:
   assert property (@(posedge clk_i) disable iff (rst_i)
      ot_now |=> (sw_en_o == '0) && !buckboost_enable_o)
   else $error("enables left on during over-temperature");

   AST_OT_RESTORE:
   assert property (@(posedge clk_i) disable iff (rst_i)
      ot_d_ff && !ot_now
      |=> buckboost_enable_o == $past(buckboost_en_ff))
   else $error("converter enable not restored after over-temperature");

   AST_COLLAPSE_STICKY:
   assert property (@(posedge clk_i) disable iff (rst_i)
      fall_edge |=> int_stat_ff[ssv_pkg::INT_COLLAPSE])
   else $error("collapse status bit lost");

   AST_IRQ_RAISE:
   assert property (@(posedge clk_i) disable iff (rst_i)
      (int_stat_ff & int_mask_ff) != '0 |=> irq_o)
   else $error("interrupt low with an unmasked status bit");

   AST_IRQ_QUIET:
   assert property (@(posedge clk_i) disable iff (rst_i)
      (int_stat_ff & int_mask_ff) == '0 |=> !irq_o)
   else $error("interrupt high with no unmasked status bit");

   // one wait state, ready for exactly one cycle
   AST_APB_ONE_WAIT:
   assert property (@(posedge clk_i) disable iff (rst_i)
      acc && !pready_ff |=> pready_o)
   else $error("apb access not answered after one wait state");

   AST_APB_PULSE:
   assert property (@(posedge clk_i) disable iff (rst_i)
      pready_o |=> !pready_o)
   else $error("ready held for more than one cycle");

endmodule : ssv_supply_path_supervisor

// ---- bench/tb_top.sv ----
// directed bench for the supply path supervisor: apb tasks, sense stimulus, pin checks
// assumes the design answers apb with one wait state and updates pins within two cycles of inputs
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   ssv_pkg::ssv_sense_t sense = '0;
   ssv_pkg::ssv_vmax_t vmax;
   logic buckboost_enable;
   logic [7:0] sw_en;
   logic ot;
   logic irq;
   int errors = 0;
   int n_checks = 0;
   logic [31:0] e3;

   always #2.5 clk_i = ~clk_i;

   ssv_supply_path_supervisor ssv_supply_path_supervisor_i (
      .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .sense_i(sense), .vmax_o(vmax), .buckboost_enable_o(buckboost_enable),
      .sw_en_o(sw_en), .overtemp_o(ot), .irq_o(irq)
   );

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // outputs are read at the edge, before it updates them; inputs change there by nba
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
   endtask : step

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      // no local limit: only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge clk_i);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk(q, exp);
      chk({31'h0, e}, {31'h0, exp_e});
   endtask : rd

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      step(1);
      chk({16'h0, pready, pslverr, irq, ot, buckboost_enable, sw_en, vmax}, 32'h0000_0000);
      chk(prdata, 32'h0000_0000);
      rd(ssv_pkg::OFF_CTRL, 32'h0000_0000, 1'b0);
      rd(ssv_pkg::OFF_RECOV_SEL, 32'h0000_0000, 1'b0);
      rd(ssv_pkg::OFF_INT_MASK, 32'h0000_0000, 1'b0);
      rd(8'h40, 32'h0000_0000, 1'b1);
      $display("test reset_and_map done");
      // every selection code: converter on, then off with the rail below battery
      for (int c = 0; c < 8; c++) begin
         sense.buckboost_output_rail_low <= 1'b0;
         wr(ssv_pkg::OFF_CTRL, 32'h0000_0008 | c);
         step(4);
         chk({29'h0, vmax}, 32'h0000_0005);
         wr(ssv_pkg::OFF_CTRL, 32'h0000_0000 | c);
         step(4);
         // modes that follow the converter keep doing so until its output drops
         e3 = (c[1] || c[2]) ? 32'h5 : (c[0] ? 32'h0 : 32'h2);
         chk({29'h0, vmax}, e3);
         sense.buckboost_output_rail_low <= 1'b1;
         step(3);
         e3 = c[1] ? 32'h6 : (c[0] ? 32'h0 : 32'h2);
         chk({29'h0, vmax}, e3);
         sense.buckboost_output_rail_low <= 1'b0;
         step(3);
         if (c[1]) begin
            chk({29'h0, vmax}, 32'h0000_0005);
         end else begin
            chk({29'h0, vmax}, e3);
         end
      end
      wr(ssv_pkg::OFF_CTRL, 32'h0000_0002);
      step(3);
      chk({29'h0, vmax}, 32'h0000_0005);
      wr(ssv_pkg::OFF_CTRL, 32'h0000_0000);
      step(3);
      chk({29'h0, vmax}, 32'h0000_0002);
      $display("test supply_select done");
      sense.buckboost_output_rail_low <= 1'b0;
      wr(ssv_pkg::OFF_CTRL, 32'h0000_FF08);
      wr(ssv_pkg::OFF_RECOV_SEL, 32'h0000_000F);
      wr(ssv_pkg::OFF_INT_MASK, 32'h0000_0007);
      step(3);
      sense.vin_fall <= 1'b1;
      step(3);
      chk({24'h0, sw_en}, 32'h0000_00F0);
      chk({31'h0, irq}, 32'h0000_0001);
      rd(ssv_pkg::OFF_INT_STAT, 32'h0000_0001, 1'b0);
      rd(ssv_pkg::OFF_STATUS, 32'h00F0_0F15, 1'b0);
      wr(ssv_pkg::OFF_INT_STAT, 32'h0000_0001);
      step(3);
      chk({31'h0, irq}, 32'h0000_0000);
      sense.vin_fall <= 1'b0;
      sense.vin_rise <= 1'b1;
      step(3);
      chk({24'h0, sw_en}, 32'h0000_00FF);
      rd(ssv_pkg::OFF_INT_STAT, 32'h0000_0002, 1'b0);
      wr(ssv_pkg::OFF_INT_STAT, 32'h0000_0002);
      sense.vin_rise <= 1'b0;
      $display("test collapse_recovery done");
      // thermal events are masked here, so the interrupt line must stay low
      wr(ssv_pkg::OFF_INT_MASK, 32'h0000_0000);
      for (int i = 0; i < 2; i++) begin
         if (i == 0) sense.ot_buckboost <= 1'b1;
         else sense.ot_central <= 1'b1;
         step(3);
         chk({31'h0, ot}, 32'h0000_0001);
         chk({23'h0, buckboost_enable, sw_en}, 32'h0000_0000);
         chk({31'h0, irq}, 32'h0000_0000);
         rd(ssv_pkg::OFF_INT_STAT, 32'h0000_0004, 1'b0);
         sense.ot_buckboost <= 1'b0;
         sense.ot_central <= 1'b0;
         step(3);
         chk({31'h0, ot}, 32'h0000_0000);
         chk({23'h0, buckboost_enable, sw_en}, 32'h0000_01FF);
         wr(ssv_pkg::OFF_INT_STAT, 32'h0000_0004);
      end
      $display("test thermal done");
      wrap_up();
   end

   // the whole run needs well under a thousand cycles
   initial begin
      #50000;
      errors++;
      wrap_up();
   end
endmodule : tb_top
